// ### rtl/aiom_bus_if.sv
// single-bit addressed i/o bus between controller and analogue module
`timescale 1ns/10ps
interface aiom_bus_if;
    import aiom_pkg::*;
    logic [BUS_ADDR_W-1:0] io_addr;   // full bus address, base plus offset
    logic                  io_wr;     // write strobe, one cycle per bit
    logic                  io_wdata;  // bit written
    logic                  io_rd;     // read strobe, one cycle per bit
    logic                  io_rdata;  // bit read, valid the cycle after io_rd

    modport host (
        output io_addr,
        output io_wr,
        output io_wdata,
        output io_rd,
        input  io_rdata
    );

    modport device (
        input  io_addr,
        input  io_wr,
        input  io_wdata,
        input  io_rd,
        output io_rdata
    );
endinterface

// ### rtl/aiom_conv_timer.sv
// conversion timer: counts a fixed number of cycles after each start
`timescale 1ns/10ps
module aiom_conv_timer
    import aiom_pkg::*;
#(
    parameter int unsigned CYCLES = 16
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam logic [TIMER_W-1:0] LOAD = TIMER_W'(CYCLES);

    logic [TIMER_W-1:0] count_ff;
    logic               done_ff;

    // down counter; a start while running restarts the full time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else if (start) begin
            count_ff <= LOAD;
        end else if (count_ff != '0) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    // one-cycle pulse as the count expires
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (count_ff == TIMER_W'(1)) && !start;
        end
    end

    assign busy = (count_ff != '0);
    assign done = done_ff;
endmodule // aiom_conv_timer

// ### rtl/aiom_device.sv
// module end: decodes the 16 bus bits, runs a/d and d/a sequencing
`timescale 1ns/10ps
module aiom_device
    import aiom_pkg::*;
#(
    parameter logic [BUS_ADDR_W-1:0] BASE_ADDR = BASE_DEFAULT
) (
    // clock and reset
    input  wire logic                               clock,
    input  wire logic                               rst,
    // controller side
    aiom_bus_if.device                              bus,
    // converter front end
    input  wire logic [CODE_W-1:0]                  adc_sample,
    output logic      [CHAN_W-1:0]                  adc_chan,
    output logic                                    adc_start,
    output logic                                    adc_busy,
    // output channels
    output logic      [OUT_CHANNELS-1:0][CODE_W-1:0] dac_code,
    output logic      [OUT_CHANNELS-1:0]            dac_load,
    output logic      [OUT_CHANNELS-1:0]            dac_busy
);
    logic                  hit;
    logic [OFFSET_W-1:0]   offset;
    logic                  wr_hit;
    logic                  rd_hit;
    logic [CODE_W-1:0]     data_ff;
    logic [CHAN_W-1:0]     chan_sel_ff;
    logic [CODE_W-1:0]     result_ff;
    logic                  rdata_ff;
    logic                  adc_trig;
    logic                  adc_running;
    logic                  adc_done;
    logic                  adc_start_ff;

    // address decode: the top nibble picks the module, the low nibble the bit
    // a base with a nonzero low nibble still owns the whole block of 16
    assign hit    = (bus.io_addr[BUS_ADDR_W-1:OFFSET_W] == BASE_ADDR[BUS_ADDR_W-1:OFFSET_W]);
    assign offset = bus.io_addr[OFFSET_W-1:0];
    assign wr_hit = bus.io_wr && hit;
    assign rd_hit = bus.io_rd && hit;

    // data bits at offsets 0-11 form the shift-in word, lsb at offset 0
    // select and trigger writes land here too; harmless, since the controller
    // writes its whole word again right before an output trigger
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_ff <= CODE_RESET;
        end else if (wr_hit && (offset <= OFF_DATA_LAST)) begin
            data_ff[offset] <= bus.io_wdata;
        end
    end

    // setting a bit at offsets 0-3 selects that input channel
    // clearing one leaves the choice alone: the last set bit wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chan_sel_ff <= '0;
        end else if (wr_hit && bus.io_wdata && (offset <= OFF_IN_LAST)) begin
            chan_sel_ff <= offset[CHAN_W-1:0];
        end
    end

    // clearing bit 8 triggers a conversion; a trigger during one is ignored
    // so the result never mixes two channels
    // limitation: such a trigger is lost, not queued
    assign adc_trig = wr_hit && !bus.io_wdata && (offset == OFF_ADC_TRIG) && !adc_running;

    // busy time is the worst case, whatever the converter really needs
    aiom_conv_timer #(
        .CYCLES (ADC_CYCLES)
    ) aiom_conv_timer_i (
        .clock (clock),
        .rst   (rst),
        .start (adc_trig),
        .busy  (adc_running),
        .done  (adc_done)
    );

    // start pulse to the converter, one cycle after the trigger write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            adc_start_ff <= 1'b0;
        end else begin
            adc_start_ff <= adc_trig;
        end
    end

    // the sample is taken as the conversion time expires
    // the converter must hold its code until then; only one sample is taken
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result_ff <= CODE_RESET;
        end else if (adc_done) begin
            result_ff <= adc_sample;
        end
    end

    // read path: result bits at 0-11, busy at 15, all else reads zero
    // registered, so a bit stands exactly one cycle after its strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= 1'b0;
        end else if (rd_hit) begin
            if (offset <= OFF_DATA_LAST) begin
                rdata_ff <= result_ff[offset];
            end else if (offset == OFF_BUSY) begin
                rdata_ff <= adc_running;
            end else begin
                rdata_ff <= 1'b0;
            end
        end else begin
            rdata_ff <= 1'b0;
        end
    end

    // outputs to the bus and the converter front end
    assign bus.io_rdata = rdata_ff;
    assign adc_chan     = chan_sel_ff;
    assign adc_start    = adc_start_ff;
    assign adc_busy     = adc_running;

    // one identical d/a path per output channel
    // each path has its own timer, so both outputs may convert at once
    genvar g;
    generate
        for (g = 0; g < OUT_CHANNELS; g++) begin : g_out
            localparam logic [OFFSET_W-1:0] MY_OFF = OFF_OUT_FIRST + OFFSET_W'(g);
            logic              sel_ff;
            logic              trig;
            logic [CODE_W-1:0] pending_ff;
            logic [CODE_W-1:0] code_ff;
            logic              load_ff;
            logic              running;
            logic              finished;

            // channel bit follows the controller's writes
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    sel_ff <= 1'b0;
                end else if (wr_hit && (offset == MY_OFF)) begin
                    sel_ff <= bus.io_wdata;
                end
            end

            // only a one-to-zero change of a set channel bit triggers
            // writing zero to a bit that is already clear does nothing
            assign trig = wr_hit && (offset == MY_OFF) && !bus.io_wdata && sel_ff;

            // word captured at the trigger, so later data writes cannot disturb it
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    pending_ff <= CODE_RESET;
                end else if (trig) begin
                    pending_ff <= data_ff;
                end
            end

            // settling time is the worst case for every range option
            aiom_conv_timer #(
                .CYCLES (DAC_CYCLES)
            ) aiom_conv_timer_i (
                .clock (clock),
                .rst   (rst),
                .start (trig),
                .busy  (running),
                .done  (finished)
            );

            // output updates once the conversion time is over and then holds
            // the old code stays on the pin for the whole conversion time
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    code_ff <= CODE_RESET;
                end else if (finished) begin
                    code_ff <= pending_ff;
                end
            end

            // load pulse marks the moment the new value appears
            // so dac_load and the new code change on the same edge
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    load_ff <= 1'b0;
                end else begin
                    load_ff <= finished;
                end
            end

            assign dac_code[g] = code_ff;
            assign dac_load[g] = load_ff;
            assign dac_busy[g] = running;
        end
    endgenerate
endmodule // aiom_device

// ### rtl/aiom_host.sv
// controller end: drives the bit-addressed bus for reads and writes
`timescale 1ns/10ps
module aiom_host
    import aiom_pkg::*;
#(
    parameter logic [BUS_ADDR_W-1:0] BASE_ADDR = BASE_DEFAULT,
    parameter int unsigned           RTD_WAIT  = RTD_WAIT_CYCLES
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // bus to the module
    aiom_bus_if.host                bus,
    // read request
    input  wire logic               rd_req,
    input  wire logic [CHAN_W-1:0]  rd_chan,
    input  wire logic               rd_rtd,
    output logic      [CODE_W-1:0]  rd_value,
    output logic                    rd_valid,
    // write request
    input  wire logic               wr_req,
    input  wire logic               wr_chan,
    input  wire logic [CODE_W-1:0]  wr_value,
    output logic                    wr_done,
    // status
    output logic                    host_busy
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_RTDW, ST_TRIG, ST_POLL, ST_POLL_W, ST_POLL_C,
        ST_RBIT, ST_RBIT_W, ST_RBIT_C, ST_WBIT, ST_OSEL, ST_OTRIG
    } aiom_state_type;

    aiom_state_type         state_ff;
    logic [BIT_IDX_W-1:0]   bit_ff;
    logic [RTD_CNT_W-1:0]   wait_ff;
    logic [CODE_W-1:0]      value_ff;
    logic                   chan_ff;
    logic [BUS_ADDR_W-1:0]  addr_ff;
    logic                   wr_ff;
    logic                   rd_ff;
    logic                   wdata_ff;
    logic                   rd_valid_ff;
    logic                   wr_done_ff;

    // sequencer and registered bus strobes; strobes last one cycle by default
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff    <= ST_IDLE;
            bit_ff      <= '0;
            wait_ff     <= '0;
            value_ff    <= CODE_RESET;
            chan_ff     <= 1'b0;
            addr_ff     <= BASE_ADDR;
            wr_ff       <= 1'b0;
            rd_ff       <= 1'b0;
            wdata_ff    <= 1'b0;
            rd_valid_ff <= 1'b0;
            wr_done_ff  <= 1'b0;
        end else begin
            wr_ff       <= 1'b0;
            rd_ff       <= 1'b0;
            rd_valid_ff <= 1'b0;
            wr_done_ff  <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    bit_ff <= '0;
                    if (rd_req) begin
                        // select the input channel first; reads take priority
                        addr_ff  <= BASE_ADDR + BUS_ADDR_W'(rd_chan);
                        wdata_ff <= 1'b1;
                        wr_ff    <= 1'b1;
                        wait_ff  <= RTD_CNT_W'(RTD_WAIT);
                        state_ff <= rd_rtd ? ST_RTDW : ST_TRIG;
                    end else if (wr_req) begin
                        value_ff <= wr_value;
                        chan_ff  <= wr_chan;
                        state_ff <= ST_WBIT;
                    end
                end
                ST_RTDW: begin
                    // sensor current must settle before the trigger
                    if (wait_ff <= RTD_CNT_W'(1)) begin
                        state_ff <= ST_TRIG;
                    end
                    wait_ff <= wait_ff - 1'b1;
                end
                ST_TRIG: begin
                    addr_ff  <= BASE_ADDR + BUS_ADDR_W'(OFF_ADC_TRIG);
                    wdata_ff <= 1'b0;
                    wr_ff    <= 1'b1;
                    state_ff <= ST_POLL;
                end
                ST_POLL: begin
                    addr_ff  <= BASE_ADDR + BUS_ADDR_W'(OFF_BUSY);
                    rd_ff    <= 1'b1;
                    state_ff <= ST_POLL_W;
                end
                ST_POLL_W: state_ff <= ST_POLL_C;
                ST_POLL_C: begin
                    // keep polling while the busy bit is high
                    state_ff <= bus.io_rdata ? ST_POLL : ST_RBIT;
                end
                ST_RBIT: begin
                    addr_ff  <= BASE_ADDR + BUS_ADDR_W'(bit_ff);
                    rd_ff    <= 1'b1;
                    state_ff <= ST_RBIT_W;
                end
                ST_RBIT_W: state_ff <= ST_RBIT_C;
                ST_RBIT_C: begin
                    value_ff[bit_ff] <= bus.io_rdata;
                    if (bit_ff == LAST_BIT) begin
                        rd_valid_ff <= 1'b1;
                        state_ff    <= ST_IDLE;
                    end else begin
                        bit_ff   <= bit_ff + 1'b1;
                        state_ff <= ST_RBIT;
                    end
                end
                ST_WBIT: begin
                    // data bits back to back, lsb at offset 0
                    addr_ff  <= BASE_ADDR + BUS_ADDR_W'(bit_ff);
                    wdata_ff <= value_ff[bit_ff];
                    wr_ff    <= 1'b1;
                    bit_ff   <= bit_ff + 1'b1;
                    if (bit_ff == LAST_BIT) begin
                        state_ff <= ST_OSEL;
                    end
                end
                ST_OSEL: begin
                    addr_ff  <= BASE_ADDR + BUS_ADDR_W'(OFF_OUT_FIRST) + BUS_ADDR_W'(chan_ff);
                    wdata_ff <= 1'b1;
                    wr_ff    <= 1'b1;
                    state_ff <= ST_OTRIG;
                end
                ST_OTRIG: begin
                    wdata_ff   <= 1'b0;
                    wr_ff      <= 1'b1;
                    wr_done_ff <= 1'b1;
                    state_ff   <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    assign bus.io_addr  = addr_ff;
    assign bus.io_wr    = wr_ff;
    assign bus.io_rd    = rd_ff;
    assign bus.io_wdata = wdata_ff;
    assign rd_value     = value_ff;
    assign rd_valid     = rd_valid_ff;
    assign wr_done      = wr_done_ff;
    assign host_busy    = (state_ff != ST_IDLE);
endmodule // aiom_host

// ### rtl/aiom_pkg.sv
// shared constants for the analogue i/o module bus port
package aiom_pkg;
    // bus geometry
    localparam int unsigned BUS_ADDR_W   = 8;
    localparam int unsigned OFFSET_W     = 4;
    localparam int unsigned CODE_W       = 12;
    localparam int unsigned IN_CHANNELS  = 4;
    localparam int unsigned OUT_CHANNELS = 2;
    localparam int unsigned CHAN_W       = 2;
    localparam int unsigned BIT_IDX_W    = 4;

    // offsets above the module base address
    localparam logic [OFFSET_W-1:0] OFF_IN_FIRST  = 4'h0;
    localparam logic [OFFSET_W-1:0] OFF_IN_LAST   = 4'h3;
    localparam logic [OFFSET_W-1:0] OFF_DATA_LAST = 4'hb;
    localparam logic [OFFSET_W-1:0] OFF_ADC_TRIG  = 4'h8;
    localparam logic [OFFSET_W-1:0] OFF_OUT_FIRST = 4'hc;
    localparam logic [OFFSET_W-1:0] OFF_BUSY      = 4'hf;
    localparam logic [BIT_IDX_W-1:0] LAST_BIT     = 4'hb;

    // reset values
    localparam logic [CODE_W-1:0]     CODE_RESET   = 12'h000;
    localparam logic [BUS_ADDR_W-1:0] BASE_DEFAULT = 8'h00;

    // timing at a 40 mhz clock
    localparam int unsigned CLOCK_PERIOD_NS = 25;
    localparam int unsigned ADC_TIME_US     = 30;
    localparam int unsigned DAC_TIME_US     = 20;
    localparam int unsigned RTD_WAIT_MS     = 10;
    // longest times round down
    localparam int unsigned ADC_CYCLES = (ADC_TIME_US * 1000) / CLOCK_PERIOD_NS;
    localparam int unsigned DAC_CYCLES = (DAC_TIME_US * 1000) / CLOCK_PERIOD_NS;
    // least time rounds up
    localparam int unsigned RTD_WAIT_CYCLES = (RTD_WAIT_MS * 1000000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned TIMER_W   = 12;
    localparam int unsigned RTD_CNT_W = 19;
endpackage

// ### testbench/aiom_bus_properties.sv
// bus-side property checker for the analogue i/o module port
`timescale 1ns/10ps
module aiom_bus_properties
    import aiom_pkg::*;
#(
    parameter logic [BUS_ADDR_W-1:0] BASE_ADDR = BASE_DEFAULT
) (
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rst,
    // bus signals
    input wire logic [BUS_ADDR_W-1:0] io_addr,
    input wire logic                  io_wr,
    input wire logic                  io_wdata,
    input wire logic                  io_rd,
    input wire logic                  io_rdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    localparam int unsigned BUSY_LIMIT = ADC_CYCLES + 6;

    logic [OFFSET_W-1:0] off;
    logic [OFFSET_W-1:0] last_rd_off_ff;
    logic                trig_seen_ff;
    logic                poll_seen_ff;
    logic                conv_wait_ff;
    logic [TIMER_W-1:0]  conv_age_ff;

    assign off = io_addr[OFFSET_W-1:0];

    // remember the last offset read, so bit order can be judged
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_rd_off_ff <= 4'h0;
        end else if (io_rd) begin
            last_rd_off_ff <= off;
        end
    end

    // trigger and busy poll seen one cycle late, to pair each with what follows
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_seen_ff <= 1'b0;
            poll_seen_ff <= 1'b0;
        end else begin
            trig_seen_ff <= io_wr && off == OFF_ADC_TRIG && !io_wdata;
            poll_seen_ff <= io_rd && off == OFF_BUSY;
        end
    end

    // cycles from the first poll until busy reads low; too long for a delay range
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            conv_wait_ff <= 1'b0;
            conv_age_ff  <= '0;
        end else if (trig_seen_ff && io_rd && off == OFF_BUSY) begin
            conv_wait_ff <= 1'b1;
            conv_age_ff  <= '0;
        end else if (conv_wait_ff) begin
            if (poll_seen_ff && !io_rdata) begin
                conv_wait_ff <= 1'b0;
            end else if (conv_age_ff != '1) begin
                conv_age_ff <= conv_age_ff + 1'b1;
            end
        end
    end

    AST_ADDR_IN_WINDOW: assert property (
        (io_wr || io_rd) |-> io_addr[BUS_ADDR_W-1:OFFSET_W] == BASE_ADDR[BUS_ADDR_W-1:OFFSET_W])
        else $error("bus access outside the module window");
    AST_RDATA_QUIET: assert property (
        !$past(io_rd) |-> !io_rdata)
        else $error("read data high without a read the cycle before");
    AST_TRIG_NEXT: assert property (
        (io_wr && off == OFF_ADC_TRIG && !io_wdata) |=>
        ((io_rd && off == OFF_BUSY) || (io_wr && off == 4'h9)))
        else $error("trigger not followed by a busy poll");
    AST_BUSY_SEEN: assert property (
        (io_wr && off == OFF_ADC_TRIG && !io_wdata ##1 io_rd && off == OFF_BUSY) |=> io_rdata)
        else $error("busy bit low right after a trigger");
    AST_BUSY_BOUND: assert property (
        conv_wait_ff |-> conv_age_ff <= TIMER_W'(BUSY_LIMIT))
        else $error("conversion busy for too long");
    AST_FIRST_BIT: assert property (
        (io_rd && off == OFF_BUSY ##1 !io_rdata) |-> ##[1:4] (io_rd && off == OFF_IN_FIRST))
        else $error("result read does not start at the lsb");
    AST_BIT_ORDER: assert property (
        (io_rd && off != OFF_IN_FIRST && off <= OFF_DATA_LAST) |-> last_rd_off_ff == off - 4'h1)
        else $error("result bits read out of order");
    AST_BIT_PACE: assert property (
        (io_rd && off < OFF_DATA_LAST) |-> ##[2:4] io_rd)
        else $error("result read stalled between bits");
    AST_WR_TAIL: assert property (
        (io_wr && off == 4'ha) |=> (io_wr && off == OFF_DATA_LAST))
        else $error("data bits not written in ascending order");
    AST_CHAN_SET: assert property (
        (io_wr && off == OFF_DATA_LAST) |=> (io_wr && io_wdata && (off == OFF_OUT_FIRST || off == 4'hd)))
        else $error("output channel not selected after data");
    AST_DA_TRIGGER: assert property (
        (io_wr && io_wdata && (off == OFF_OUT_FIRST || off == 4'hd)) |=> (io_wr && !io_wdata && $stable(io_addr)))
        else $error("output channel bit not cleared to start the d/a");
endmodule // aiom_bus_properties

// ### testbench/analog_io_module_bus_port_tb.sv
// self-checking bench joining the host and module ends of the analogue i/o port
`timescale 1ns/10ps
module analog_io_module_bus_port_tb;
    import aiom_pkg::*;
    localparam logic [BUS_ADDR_W-1:0] BASE    = 8'h50;
    localparam int unsigned           RTD_SIM = 20;

    logic                                 clock;
    logic                                 rst;
    logic      [CODE_W-1:0]               adc_sample;
    logic      [CHAN_W-1:0]               adc_chan;
    logic                                 adc_start;
    logic                                 adc_busy;
    logic      [OUT_CHANNELS-1:0][CODE_W-1:0] dac_code;
    logic      [OUT_CHANNELS-1:0]         dac_load;
    logic      [OUT_CHANNELS-1:0]         dac_busy;
    logic                                 rd_req;
    logic      [CHAN_W-1:0]               rd_chan;
    logic                                 rd_rtd;
    logic      [CODE_W-1:0]               rd_value;
    logic                                 rd_valid;
    logic                                 wr_req;
    logic                                 wr_chan;
    logic      [CODE_W-1:0]               wr_value;
    logic                                 wr_done;
    logic                                 host_busy;
    logic      [CODE_W-1:0]               exp_dac [2];
    logic      [CODE_W-1:0]               codes [4];
    int                                   miscompares;
    int                                   tests_run;

    aiom_bus_if bus_if ();

    aiom_device #(.BASE_ADDR(BASE)) aiom_device_i (
        .clock(clock), .rst(rst), .bus(bus_if.device), .adc_sample(adc_sample), .adc_chan(adc_chan),
        .adc_start(adc_start), .adc_busy(adc_busy), .dac_code(dac_code), .dac_load(dac_load),
        .dac_busy(dac_busy));

    aiom_host #(.BASE_ADDR(BASE), .RTD_WAIT(RTD_SIM)) aiom_host_i (
        .clock(clock), .rst(rst), .bus(bus_if.host), .rd_req(rd_req), .rd_chan(rd_chan), .rd_rtd(rd_rtd),
        .rd_value(rd_value), .rd_valid(rd_valid), .wr_req(wr_req), .wr_chan(wr_chan), .wr_value(wr_value),
        .wr_done(wr_done), .host_busy(host_busy));

    aiom_bus_properties #(.BASE_ADDR(BASE)) aiom_bus_properties_i (
        .clock(clock), .rst(rst), .io_addr(bus_if.io_addr), .io_wr(bus_if.io_wr),
        .io_wdata(bus_if.io_wdata), .io_rd(bus_if.io_rd), .io_rdata(bus_if.io_rdata));

    // 40 mhz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input string what, input logic [CODE_W-1:0] exp, input logic [CODE_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one full conversion through the host; sample held steady for the whole window
    task automatic do_read(input logic [CHAN_W-1:0] ch, input logic rtd, input logic [CODE_W-1:0] code);
        int n;
        int busy_n;
        int starts;
        int lat;
        n = 0;
        busy_n = 0;
        starts = 0;
        lat = 0;
        adc_sample = code;
        rd_chan = ch;
        rd_rtd = rtd;
        rd_req = 1'b1;
        @(negedge clock);
        rd_req = 1'b0;
        while (rd_valid !== 1'b1 && n < 3000) begin
            busy_n += (adc_busy === 1'b1);
            starts += (adc_start === 1'b1);
            lat += (starts == 0);
            n++;
            @(negedge clock);
        end
        check("read valid", 12'h001, {11'h000, rd_valid});
        check("host idle after read", 12'h000, {11'h000, host_busy});
        check("read value", code, rd_value);
        check("selected channel", {10'h000, ch}, {10'h000, adc_chan});
        check("conversion starts", 12'h001, 12'(starts));
        check("busy span", 12'h001, {11'h000, busy_n >= 1 && busy_n <= int'(ADC_CYCLES)});
        if (rtd) begin
            check("sensor settle wait", 12'h001, {11'h000, lat >= RTD_SIM});
        end
        $display("test read channel %0d done", ch);
    endtask

    // one output update; the other channel must keep its code meanwhile
    task automatic do_write(input logic ch, input logic [CODE_W-1:0] val);
        int n;
        int busy_n;
        int dones;
        n = 0;
        busy_n = 0;
        dones = 0;
        wr_chan = ch;
        wr_value = val;
        wr_req = 1'b1;
        @(negedge clock);
        wr_req = 1'b0;
        while (dac_load[ch] !== 1'b1 && n < 2000) begin
            busy_n += (dac_busy[ch] === 1'b1);
            dones += (wr_done === 1'b1);
            n++;
            @(negedge clock);
        end
        check("output load", 12'h001, {11'h000, dac_load[ch]});
        check("write done pulses", 12'h001, 12'(dones));
        check("host idle after write", 12'h000, {11'h000, host_busy});
        check("output code", val, dac_code[ch]);
        check("other output held", exp_dac[!ch], dac_code[!ch]);
        check("d/a span", 12'h001, {11'h000, busy_n >= 1 && busy_n <= int'(DAC_CYCLES)});
        exp_dac[ch] = val;
        $display("test write channel %0d done", ch);
    endtask

    // main sequence: reads on every input channel back to back, then output updates
    initial begin
        rst = 1'b1;
        rd_req = 1'b0;
        rd_chan = 2'h0;
        rd_rtd = 1'b0;
        wr_req = 1'b0;
        wr_chan = 1'b0;
        wr_value = 12'h000;
        adc_sample = 12'h000;
        miscompares = 0;
        tests_run = 0;
        exp_dac = '{12'h000, 12'h000};
        codes = '{12'h000, 12'ha5c, 12'hfff, 12'h5a3};
        repeat (2) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check("reset code 0", 12'h000, dac_code[0]);
        check("reset code 1", 12'h000, dac_code[1]);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            do_read(CHAN_W'(i), i == 1, codes[i]);
        end
        do_write(1'b1, 12'h9a5);
        do_write(1'b0, 12'hfff);
        do_write(1'b1, 12'h000);
        final_report;
    end

    // watchdog: whole run is under ten thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        $display("ERROR watchdog expected finish seen hang");
        final_report;
    end
endmodule // analog_io_module_bus_port_tb
